// ### design/mls_frame_if.sv
// Carrier between the core and the management frame observer
`timescale 1ns/10ps
`default_nettype none
interface mls_frame_if;
  logic mdc_rise;
  logic mdio_bit;
  logic done;
  logic [4:0] phy_addr;
  logic ack;
  logic link;

  modport observer (input mdc_rise, input mdio_bit,
                    output done, output phy_addr, output ack, output link);
  modport core (output mdc_rise, output mdio_bit,
                input done, input phy_addr, input ack, input link);
endinterface : mls_frame_if
`default_nettype wire

// ### design/mls_frame_obs.sv
// Watches management frames and reports finished status register reads
`timescale 1ns/10ps
`default_nettype none
module mls_frame_obs
  import mls_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // Frame carrier
  mls_frame_if.observer fr
);

  mls_obs_state_t state;
  logic [4:0] cnt;
  logic [HEAD_BITS-1:0] head;
  logic ack_seen;
  logic link_seen;
  logic status_read;

  assign status_read = (head[OP_MSB -: 2] == OP_READ)
                    && (head[REG_MSB -: 5] == GEN_STATUS_REG);

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= OBS_IDLE;
      cnt <= 5'h00;
    end else if (fr.mdc_rise) begin
      case (state)
        OBS_IDLE: begin
          // Preamble and idle bus read as ones; the first zero starts a frame
          if (!fr.mdio_bit) begin
            state <= OBS_HEAD;
            cnt <= 5'h00;
          end
        end
        OBS_HEAD: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(HEAD_BITS - 1)) begin
            state <= OBS_TURN;
            cnt <= 5'h00;
          end
        end
        OBS_TURN: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h01) begin
            state <= OBS_DATA;
            cnt <= 5'h00;
          end
        end
        OBS_DATA: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'(DATA_BITS - 1)) begin
            state <= OBS_IDLE;
          end
        end
        default: state <= OBS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      head <= '0;
      ack_seen <= 1'b0;
      link_seen <= 1'b0;
    end else if (fr.mdc_rise) begin
      if (state == OBS_HEAD) begin
        head <= {head[HEAD_BITS-2:0], fr.mdio_bit};
      end
      // The device answers by pulling the second turnaround bit low
      if (state == OBS_TURN && cnt == 5'h01) begin
        ack_seen <= !fr.mdio_bit;
      end
      if (state == OBS_DATA && cnt == 5'(DATA_BITS - 1 - LINK_STATUS_BIT)) begin
        link_seen <= fr.mdio_bit;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fr.done <= 1'b0;
      fr.phy_addr <= 5'h00;
      fr.ack <= 1'b0;
      fr.link <= 1'b0;
    end else begin
      fr.done <= fr.mdc_rise && state == OBS_DATA
              && cnt == 5'(DATA_BITS - 1) && status_read;
      if (fr.mdc_rise && state == OBS_DATA && cnt == 5'(DATA_BITS - 1)) begin
        fr.phy_addr <= head[PHY_MSB -: 5];
        fr.ack <= ack_seen;
        fr.link <= link_seen;
      end
    end
  end

endmodule : mls_frame_obs
`default_nettype wire

// ### design/mls_link_events.sv
// Per-address link state, link change events and block interrupt
`timescale 1ns/10ps
`default_nettype none
module mls_link_events
  import mls_pkg::*;
#(
  parameter int unsigned NUM_SEL = NUM_SEL_DOC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Management pins as seen by this block
  input wire logic mdc,
  input wire logic mdio_in,
  // Completion pulses from the user access channels
  input wire logic [1:0] user_cmd_done,
  // Interrupt
  output logic irq
);

  if (NUM_SEL < 1 || NUM_SEL > NUM_SEL_DOC) begin : g_bad_num_sel
    $error("NUM_SEL must lie between 1 and 2");
  end

  // Offsets are held as byte addresses of one fixed width
  if (ADDR_W != $bits(OFF_LINK_STATE)) begin : g_bad_addr
    $error("ADDR_W must match the width of the register offsets");
  end

  // One link bit per PHY address, and the whole map must fit a bus word
  if (NUM_PHY != (1 << PHY_ADDR_W) || NUM_PHY > DATA_W) begin : g_bad_phy_map
    $error("NUM_PHY must equal the PHY address space and fit the data word");
  end

  // Selector address and enable fields must not overlap
  if (SEL_ADDR_LSB + PHY_ADDR_W > SEL_IRQ_EN_BIT || SEL_IRQ_EN_BIT >= DATA_W) begin : g_bad_sel
    $error("Selector fields overlap or leave the data word");
  end

  // Every status bit needs a slot in the status, enable and clear words
  if (IRQ_W > DATA_W || IRQ_STATUS_READ >= IRQ_W || IRQ_NO_ACK >= IRQ_W
      || IRQ_LINK_CHG >= IRQ_W) begin : g_bad_irq
    $error("Interrupt status bits do not fit the status word");
  end

  // Sticky update: an incoming set beats a clear in the same cycle
  function automatic logic [1:0] w1c2(
    input logic [1:0] cur,
    input logic [1:0] clr,
    input logic [1:0] set
  );
    w1c2 = (cur & ~clr) | set;
  endfunction : w1c2

  function automatic logic [IRQ_W-1:0] w1c3(
    input logic [IRQ_W-1:0] cur,
    input logic [IRQ_W-1:0] clr,
    input logic [IRQ_W-1:0] set
  );
    w1c3 = (cur & ~clr) | set;
  endfunction : w1c3

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction : hit

  // Selector register image, shared by both selector read slots
  function automatic logic [DATA_W-1:0] sel_word(
    input logic [PHY_ADDR_W-1:0] addr,
    input logic en
  );
    sel_word = '0;
    sel_word[SEL_ADDR_LSB +: PHY_ADDR_W] = addr;
    sel_word[SEL_IRQ_EN_BIT] = en;
  endfunction : sel_word

  // Reset release
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pin synchronisers; the management clock is sampled, not used as a clock
  logic mdc_meta;
  logic mdc_sync;
  logic mdc_prev;
  logic mdio_meta;
  logic mdio_sync;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mdc_meta <= 1'b0;
      mdc_sync <= 1'b0;
      mdc_prev <= 1'b0;
    end else begin
      mdc_meta <= mdc;
      mdc_sync <= mdc_meta;
      mdc_prev <= mdc_sync;
    end
  end

  // Idle bus is pulled high, so the data synchroniser resets to one
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mdio_meta <= 1'b1;
      mdio_sync <= 1'b1;
    end else begin
      mdio_meta <= mdio_in;
      mdio_sync <= mdio_meta;
    end
  end

  // Frame observer
  mls_frame_if fr ();

  assign fr.mdc_rise = mdc_sync && !mdc_prev;
  assign fr.mdio_bit = mdio_sync;

  mls_frame_obs u_obs (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .fr(fr)
  );

  // Write decode
  logic wr_link_raw;
  logic wr_link_masked;
  logic wr_user_raw;
  logic wr_sel0;
  logic wr_sel1;
  logic wr_irq_enable;
  logic wr_irq_clear;

  assign wr_link_raw = reg_wr && hit(reg_addr, OFF_LINK_RAW);
  assign wr_link_masked = reg_wr && hit(reg_addr, OFF_LINK_MASKED);
  assign wr_user_raw = reg_wr && hit(reg_addr, OFF_USER_RAW);
  assign wr_sel0 = reg_wr && hit(reg_addr, OFF_SEL0);
  assign wr_sel1 = reg_wr && hit(reg_addr, OFF_SEL1);
  assign wr_irq_enable = reg_wr && hit(reg_addr, OFF_IRQ_ENABLE);
  assign wr_irq_clear = reg_wr && hit(reg_addr, OFF_IRQ_CLEAR);

  // User PHY selectors
  logic [4:0] sel_addr [2];
  logic [1:0] sel_irq_en;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_addr[0] <= RST_SEL_ADDR;
      sel_irq_en[0] <= RST_SEL_IRQ_EN;
    end else if (wr_sel0) begin
      sel_addr[0] <= reg_wdata[SEL_ADDR_LSB +: PHY_ADDR_W];
      sel_irq_en[0] <= reg_wdata[SEL_IRQ_EN_BIT];
    end
  end

  // A selector above NUM_SEL stays at reset and never raises events
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_addr[1] <= RST_SEL_ADDR;
      sel_irq_en[1] <= RST_SEL_IRQ_EN;
    end else if (wr_sel1 && NUM_SEL > 1) begin
      sel_addr[1] <= reg_wdata[SEL_ADDR_LSB +: PHY_ADDR_W];
      sel_irq_en[1] <= reg_wdata[SEL_IRQ_EN_BIT];
    end
  end

  // Link state; software writes never reach it
  logic [NUM_PHY-1:0] link_state;
  logic [NUM_PHY-1:0] next_link_state;
  logic new_link;

  // An unanswered read clears the bit, so a missing PHY reads as link down
  assign new_link = fr.ack && fr.link;

  always_comb begin
    next_link_state = link_state;
    if (fr.done) begin
      next_link_state[fr.phy_addr] = new_link;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_state <= RST_LINK_STATE;
    end else begin
      link_state <= next_link_state;
    end
  end

  // Change detection per selector
  logic [1:0] link_chg;

  always_comb begin
    link_chg = 2'h0;
    for (int i = 0; i < 2; i++) begin
      if (i < NUM_SEL && fr.done && fr.phy_addr == sel_addr[i]
          && link_state[fr.phy_addr] != new_link) begin
        link_chg[i] = 1'b1;
      end
    end
  end

  // Link change events
  logic [1:0] link_raw;
  logic [1:0] link_masked;
  logic [1:0] raw_clr;
  logic [1:0] masked_clr;
  logic [1:0] masked_set;

  assign raw_clr = wr_link_raw ? reg_wdata[1:0] : 2'h0;
  assign masked_clr = wr_link_masked ? reg_wdata[1:0] : 2'h0;
  assign masked_set = link_chg & sel_irq_en;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_raw <= RST_EVENT;
    end else begin
      link_raw <= w1c2(link_raw, raw_clr, link_chg);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_masked <= RST_EVENT;
    end else begin
      link_masked <= w1c2(link_masked, masked_clr, masked_set);
    end
  end

  // User command completion events, same write-one-to-clear behaviour
  logic [1:0] user_raw;
  logic [1:0] user_clr;

  assign user_clr = wr_user_raw ? reg_wdata[1:0] : 2'h0;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      user_raw <= RST_EVENT;
    end else begin
      user_raw <= w1c2(user_raw, user_clr, user_cmd_done);
    end
  end

  // Block interrupt: sticky status, enable, write-only clear
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] next_irq_enable;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_STATUS_READ] = fr.done;
    irq_set[IRQ_NO_ACK] = fr.done && !fr.ack;
    irq_set[IRQ_LINK_CHG] = |link_chg;
  end

  assign irq_clr = wr_irq_clear ? reg_wdata[IRQ_W-1:0] : '0;
  assign next_irq_status = w1c3(irq_status, irq_clr, irq_set);
  assign next_irq_enable = wr_irq_enable ? reg_wdata[IRQ_W-1:0] : irq_enable;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable <= RST_IRQ;
    end else begin
      irq_enable <= next_irq_enable;
    end
  end

  // Level output from the next values, so it changes on the same edge as the status and enable registers;
  // registered so the pin cannot glitch while the bus decodes
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & next_irq_enable);
    end
  end

  // Read mux
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFF_LINK_STATE: rd_mux = link_state;
      OFF_LINK_RAW: rd_mux[1:0] = link_raw;
      OFF_LINK_MASKED: rd_mux[1:0] = link_masked;
      OFF_USER_RAW: rd_mux[1:0] = user_raw;
      OFF_SEL0: rd_mux = sel_word(sel_addr[0], sel_irq_en[0]);
      OFF_SEL1: rd_mux = sel_word(sel_addr[1], sel_irq_en[1]);
      OFF_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status;
      OFF_IRQ_ENABLE: rd_mux[IRQ_W-1:0] = irq_enable;
      // Write-only clear register reads as zero
      OFF_IRQ_CLEAR: rd_mux = '0;
      default: rd_mux = '0;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule : mls_link_events
`default_nettype wire

// ### design/mls_pkg.sv
// Shared constants and types of the MDIO link status and event block
package mls_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PHY_ADDR_W = 5;
  localparam int unsigned NUM_PHY = 32;
  localparam int unsigned NUM_SEL_DOC = 2;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_LINK_STATE = 8'h00;
  localparam logic [7:0] OFF_LINK_RAW = 8'h04;
  localparam logic [7:0] OFF_LINK_MASKED = 8'h08;
  localparam logic [7:0] OFF_USER_RAW = 8'h0C;
  localparam logic [7:0] OFF_SEL0 = 8'h10;
  localparam logic [7:0] OFF_SEL1 = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h20;

  // Reset values
  localparam logic [31:0] RST_LINK_STATE = 32'h0000_0000;
  localparam logic [1:0] RST_EVENT = 2'h0;
  localparam logic [4:0] RST_SEL_ADDR = 5'h00;
  localparam logic RST_SEL_IRQ_EN = 1'b0;
  localparam logic [2:0] RST_IRQ = 3'h0;

  // User PHY selector fields
  localparam int unsigned SEL_ADDR_LSB = 0;
  localparam int unsigned SEL_IRQ_EN_BIT = 8;

  // Block interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_STATUS_READ = 0;
  localparam int unsigned IRQ_NO_ACK = 1;
  localparam int unsigned IRQ_LINK_CHG = 2;

  // Management frame layout as seen after the start-of-frame zero
  localparam int unsigned HEAD_BITS = 13;
  localparam int unsigned HEAD_W = 4;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [4:0] GEN_STATUS_REG = 5'h01;
  localparam int unsigned LINK_STATUS_BIT = 2;
  localparam int unsigned OP_MSB = 11;
  localparam int unsigned PHY_MSB = 9;
  localparam int unsigned REG_MSB = 4;

  typedef enum logic [1:0] {
    OBS_IDLE = 2'h0,
    OBS_HEAD = 2'h1,
    OBS_TURN = 2'h3,
    OBS_DATA = 2'h2
  } mls_obs_state_t;

endpackage : mls_pkg

// ### dv/mls_link_events_checker.sv
// Port-level assertions of the link status and event block
`timescale 1ns/10ps
`default_nettype none
module mls_link_events_checker
  import mls_pkg::*;
#(
  parameter int unsigned NUM_SEL = NUM_SEL_DOC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Pins and interrupt
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic [1:0] user_cmd_done,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // No link update can still be in flight once mdc has stood for 15 cycles
  logic mdc_q;
  logic [3:0] quiet;
  logic lk_rd;
  logic lk_ok;
  logic [31:0] lk_val;
  logic [2:0] en_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q <= 1'b0;
      quiet <= 4'h0;
    end else begin
      mdc_q <= mdc;
      quiet <= (mdc != mdc_q) ? 4'h0 : (quiet == 4'hF) ? quiet : quiet + 4'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lk_rd <= 1'b0;
      lk_ok <= 1'b0;
      lk_val <= 32'h0;
    end else begin
      lk_rd <= reg_rd && reg_addr == OFF_LINK_STATE && quiet == 4'hF;
      if (quiet != 4'hF) begin
        lk_ok <= 1'b0;
      end else if (lk_rd) begin
        lk_ok <= 1'b1;
        lk_val <= reg_rdata;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 3'h0;
    end else if (reg_wr && reg_addr == OFF_IRQ_ENABLE) begin
      en_q <= reg_wdata[2:0];
    end
  end
  sequence s_clr_raw;
    reg_wr && reg_addr == OFF_LINK_RAW && quiet == 4'hF ##1 reg_rd && reg_addr == OFF_LINK_RAW;
  endsequence
  sequence s_clr_msk;
    reg_wr && reg_addr == OFF_LINK_MASKED && quiet == 4'hF
      ##1 reg_rd && reg_addr == OFF_LINK_MASKED;
  endsequence
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_link_hold;
    lk_rd && lk_ok |-> reg_rdata == lk_val;
  endproperty
  property p_raw_rsvd;
    reg_rd && reg_addr == OFF_LINK_RAW |=> reg_rdata[31:2] == 30'h0;
  endproperty
  property p_msk_rsvd;
    reg_rd && reg_addr == OFF_LINK_MASKED |=> reg_rdata[31:2] == 30'h0;
  endproperty
  property p_raw_clr;
    s_clr_raw |=> (reg_rdata[1:0] & $past(reg_wdata[1:0], 2)) == 2'h0;
  endproperty
  property p_msk_clr;
    s_clr_msk |=> (reg_rdata[1:0] & $past(reg_wdata[1:0], 2)) == 2'h0;
  endproperty
  property p_irq_off;
    reg_wr && reg_addr == OFF_IRQ_ENABLE && reg_wdata[2:0] == 3'h0 |-> ##2 !irq;
  endproperty
  property p_irq_en;
    irq |-> en_q != 3'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_link_hold: assert property (p_link_hold) else $error("link state moved");
  a_raw_rsvd: assert property (p_raw_rsvd) else $error("raw upper bits set");
  a_msk_rsvd: assert property (p_msk_rsvd) else $error("masked upper bits set");
  a_raw_clr: assert property (p_raw_clr) else $error("raw bit not cleared");
  a_msk_clr: assert property (p_msk_clr) else $error("masked bit not cleared");
  a_irq_off: assert property (p_irq_off) else $error("irq high when disabled");
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
endmodule : mls_link_events_checker
`default_nettype wire

// ### dv/mls_phy_model.sv
// Far side of the management bus: clocks each frame and answers as a PHY
`timescale 1ns/10ps
`default_nettype none
module mls_phy_model (
  // Management pins
  output logic mdc,
  output logic mdio
);
  // Clock stands low between frames; the released data line sits on its pull-up
  initial begin
    mdc = 1'b0;
    mdio = 1'b1;
  end
  task automatic put_bit(input logic b);
    mdio = b;
    #80;
    mdc = 1'b1;
    #80;
    mdc = 1'b0;
  endtask : put_bit
  // Without an acknowledge nothing drives the line, so the pull-up reads as ones
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic ack, input logic [15:0] data);
    logic [31:0] bits;
    bits = {2'b01, op, phy, rg, 1'b1, !ack, ack ? data : 16'hFFFF};
    #3;
    repeat (32) put_bit(1'b1);
    for (int i = 31; i >= 0; i--) put_bit(bits[i]);
    mdio = 1'b1;
  endtask : frame
endmodule : mls_phy_model
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the link status and event block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import mls_pkg::*;
();
  logic clk_sys;
  logic rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic mdc;
  logic mdio;
  logic [1:0] ucd;
  logic irq;
  int fail_count;
  int n_compared;
  // Reference state
  logic [31:0] lk;
  logic [1:0] raw;
  logic [1:0] msk;
  logic [1:0] s_en;
  logic [4:0] s_ad [2];
  logic [2:0] ist;
  logic [2:0] ien;
  mls_link_events dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mdc(mdc), .mdio_in(mdio), .user_cmd_done(ucd), .irq(irq));
  mls_phy_model phy_u (.mdc(mdc), .mdio(mdio));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
    @(posedge clk_sys);
  endtask : rd
  task automatic irq_chk;
    rd(OFF_IRQ_STATUS, {29'h0, ist});
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, |(ist & ien)});
    @(posedge clk_sys);
  endtask : irq_chk
  // Only a finished status read moves the link bit or raises events
  function automatic void upd(logic [1:0] op, logic [4:0] rg, logic [4:0] p, logic ack,
                              logic [15:0] d);
    logic nb;
    if (op != OP_READ || rg != GEN_STATUS_REG) return;
    nb = ack & d[LINK_STATUS_BIT];
    ist[IRQ_STATUS_READ] = 1'b1;
    if (!ack) ist[IRQ_NO_ACK] = 1'b1;
    for (int n = 0; n < 2; n++) begin
      if (s_ad[n] == p && nb != lk[p]) begin
        raw[n] = 1'b1;
        if (s_en[n]) msk[n] = 1'b1;
        ist[IRQ_LINK_CHG] = 1'b1;
      end
    end
    lk[p] = nb;
  endfunction : upd
  initial begin
    logic [4:0] p;
    logic [4:0] rg;
    logic [1:0] op;
    logic ack;
    logic [31:0] r;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ucd = 2'h0;
    fail_count = 0;
    n_compared = 0;
    lk = 32'h0;
    raw = 2'h0;
    msk = 2'h0;
    ist = 3'h0;
    r = $urandom(1066);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int a = 0; a <= 36; a += 4) rd(8'(a), 32'h0);
    rd(8'h40, 32'h0);
    ucd <= 2'h2;
    @(posedge clk_sys);
    ucd <= 2'h0;
    rd(OFF_USER_RAW, 32'h2);
    ucd <= 2'h1;
    wr(OFF_USER_RAW, 32'h3);
    ucd <= 2'h0;
    rd(OFF_USER_RAW, 32'h1);
    wr(OFF_USER_RAW, 32'h1);
    rd(OFF_USER_RAW, 32'h0);
    for (int i = 0; i < 24; i++) begin
      if (i % 6 == 0) begin
        for (int n = 0; n < 2; n++) begin
          r = $urandom;
          s_ad[n] = r[4:0];
          s_en[n] = r[8];
          wr(OFF_SEL0 + 8'(4 * n), {23'h0, r[8], 3'h0, r[4:0]});
          rd(OFF_SEL0 + 8'(4 * n), {23'h0, r[8], 3'h0, r[4:0]});
        end
        r = $urandom;
        ien = r[2:0];
        wr(OFF_IRQ_ENABLE, {29'h0, ien});
      end
      r = $urandom;
      p = r[2] ? r[7:3] : s_ad[r[0]];
      op = (r[10:8] == 3'h0) ? 2'h1 : OP_READ;
      rg = (r[13:11] == 3'h0) ? 5'h02 : GEN_STATUS_REG;
      ack = (r[15:14] != 2'h0) || (op != OP_READ);
      phy_u.frame(op, p, rg, ack, r[31:16]);
      repeat (20) @(posedge clk_sys);
      upd(op, rg, p, ack, r[31:16]);
      wr(OFF_LINK_STATE, ~lk);
      @(posedge clk_sys);
      wr(OFF_IRQ_STATUS, 32'h7);
      rd(OFF_LINK_STATE, lk);
      rd(OFF_LINK_RAW, {30'h0, raw});
      rd(OFF_LINK_MASKED, {30'h0, msk});
      irq_chk();
      r = $urandom;
      raw &= ~r[1:0];
      msk &= ~r[3:2];
      ist &= ~r[6:4];
      wr(OFF_LINK_RAW, r);
      rd(OFF_LINK_RAW, {30'h0, raw});
      wr(OFF_LINK_MASKED, r >> 2);
      rd(OFF_LINK_MASKED, {30'h0, msk});
      wr(OFF_IRQ_CLEAR, r >> 4);
      irq_chk();
    end
    // Unanswered status read with the link bit high must still clear the bit
    phy_u.frame(OP_READ, 5'h1F, GEN_STATUS_REG, 1'b0, 16'h0004);
    repeat (20) @(posedge clk_sys);
    upd(OP_READ, GEN_STATUS_REG, 5'h1F, 1'b0, 16'h0004);
    rd(OFF_LINK_STATE, lk);
    rd(OFF_LINK_RAW, {30'h0, raw});
    wr(OFF_IRQ_ENABLE, 32'h7);
    ien = 3'h7;
    irq_chk();
    wr(OFF_IRQ_ENABLE, 32'h0);
    ien = 3'h0;
    irq_chk();
    final_report();
  end
  initial begin
    #1000000;
    fail_count++;
    final_report();
  end
endmodule : tb_top
bind mls_link_events mls_link_events_checker #(.NUM_SEL(NUM_SEL)) chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mdc(mdc), .mdio_in(mdio_in),
  .user_cmd_done(user_cmd_done), .irq(irq));
`default_nettype wire
